// ==== src/incr_exec_pkg.sv ====
// Package with register map, field layout, opcodes and states of the increment unit.
package incr_exec_pkg;

  // Register byte offsets on the APB window.
  localparam logic [7:0] CMD_OFFSET     = 8'h00;
  localparam logic [7:0] FLAGS_OFFSET   = 8'h04;
  localparam logic [7:0] REGIDX_OFFSET  = 8'h08;
  localparam logic [7:0] REGDATA_OFFSET = 8'h0c;
  localparam logic [7:0] STATUS_OFFSET  = 8'h10;
  localparam logic [7:0] RESULT_OFFSET  = 8'h14;
  localparam logic [7:0] RETIRED_OFFSET = 8'h18;

  // Command register fields.
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_BYTE_BIT  = 2;
  localparam int CMD_DEST_LSB  = 4;
  localparam int REG_IDX_WIDTH = 4;
  localparam int REG_COUNT     = 16;

  // Flag register bit positions.
  localparam int FLAG_C_BIT      = 0;
  localparam int FLAG_Z_BIT      = 1;
  localparam int FLAG_N_BIT      = 2;
  localparam int FLAG_GIE_BIT    = 3;
  localparam int FLAG_CORE_HALT_BIT_BIT = 4;
  localparam int FLAG_OSC_DISABLE_BIT_BIT = 5;
  localparam int FLAG_V_BIT      = 8;

  // Constant ORed into the flag register by the enable-interrupt operation.
  localparam logic [15:0] IRQ_ENABLE_MASK = 16'h0008;

  // Operand values that trigger the flag conditions.
  localparam logic [15:0] WORD_ALL_ONES  = 16'hffff;
  localparam logic [15:0] WORD_ONES_LESS = 16'hfffe;
  localparam logic [15:0] WORD_POS_MAX   = 16'h7fff;
  localparam logic [15:0] WORD_POS_LESS  = 16'h7ffe;
  localparam logic [7:0]  BYTE_ALL_ONES  = 8'hff;
  localparam logic [7:0]  BYTE_ONES_LESS = 8'hfe;
  localparam logic [7:0]  BYTE_POS_MAX   = 8'h7f;
  localparam logic [7:0]  BYTE_POS_LESS  = 8'h7e;

  // Register file index of the stack pointer.
  localparam logic [3:0] STACK_POINTER_REG = 4'h1;

  // Reset values.
  localparam logic [15:0] FLAGS_RESET   = 16'h0000;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  // Operation codes carried in the command register.
  typedef enum logic [1:0] {
    OP_NONE       = 2'h0,
    OP_IRQ_ENABLE = 2'h1,
    OP_INCR_ONE   = 2'h2,
    OP_INCR_TWO   = 2'h3
  } op_t;

  // Execution sequence, Gray coded along idle, fetch, execute.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b11
  } state_t;

endpackage

// ==== src/reg_file_mem.sv ====
// Small general register file with one write port and a registered read port.
`timescale 1ns/10ps

module reg_file_mem (
  // Clock.
  input  wire logic        clk,
  // Write port.
  input  wire logic        wrEn,
  input  wire logic [3:0]  wrAddr,
  input  wire logic [15:0] wrData,
  // Read port.
  input  wire logic [3:0]  rdAddr,
  output logic      [15:0] rdData
);

  logic [15:0] store [16];

  // Contents are not reset; software loads registers before use.
  always_ff @(posedge clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  // Read data lands one cycle after the address.
  always_ff @(posedge clk) begin
    rdData <= store[rdAddr];
  end

endmodule

// ==== src/incr_exec.sv ====
// Execution unit for enable-interrupt and single or double increment, with APB access.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/10ps

module incr_exec (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core side.
  input  wire logic        irqRequest,
  input  wire logic        instrRetire,
  output logic             irqGrant,
  output logic             globalIrqEnable
);

  // Register decode result.
  typedef enum logic [2:0] {
    SEL_CMD     = 3'h0,
    SEL_FLAGS   = 3'h1,
    SEL_REGIDX  = 3'h2,
    SEL_REGDATA = 3'h3,
    SEL_STATUS  = 3'h4,
    SEL_RESULT  = 3'h5,
    SEL_RETIRED = 3'h6,
    SEL_NONE    = 3'h7
  } sel_t;

  // Flag outcome of one operation.
  typedef struct packed {
    logic [15:0] result;
    logic        n;
    logic        z;
    logic        c;
    logic        v;
  } outcome_t;

  incr_exec_pkg::state_t state;
  incr_exec_pkg::op_t    curOp;
  logic                  curByte;
  logic [3:0]            curDest;
  logic [15:0]           flagRegister;
  logic [3:0]            regIdx;
  logic [15:0]           lastResult;
  logic [15:0]           retired;
  logic [7:0]            lastCmd;
  logic                  shadow;
  logic                  ackPending;
  logic                  busy;
  logic                  apbDone;
  logic                  apbWrite;
  logic                  apbRead;
  sel_t                  accessSel;
  logic [15:0]           memRdData;
  logic                  memWrEn;
  logic [3:0]            memWrAddr;
  logic [15:0]           memWrData;
  logic [3:0]            memRdAddr;
  outcome_t              outcome;
  logic                  execDone;
  logic                  instrDone;
  logic                  wbLag;

  // Address decoding, shared by the read and write paths.
  function automatic sel_t decode(input logic [7:0] addr);
    if (addr == incr_exec_pkg::CMD_OFFSET) begin
      decode = SEL_CMD;
    end else if (addr == incr_exec_pkg::FLAGS_OFFSET) begin
      decode = SEL_FLAGS;
    end else if (addr == incr_exec_pkg::REGIDX_OFFSET) begin
      decode = SEL_REGIDX;
    end else if (addr == incr_exec_pkg::REGDATA_OFFSET) begin
      decode = SEL_REGDATA;
    end else if (addr == incr_exec_pkg::STATUS_OFFSET) begin
      decode = SEL_STATUS;
    end else if (addr == incr_exec_pkg::RESULT_OFFSET) begin
      decode = SEL_RESULT;
    end else if (addr == incr_exec_pkg::RETIRED_OFFSET) begin
      decode = SEL_RETIRED;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  // Result and arithmetic flags of an increment by one or two.
  // The zero, carry and overflow tests look at the operand, not at the result,
  // because each condition is stated on the original destination value.
  function automatic outcome_t increment(input logic [15:0] dst, input logic byteMode,
                                         input logic twoStep);
    outcome_t o;
    logic [7:0] lo;
    o  = '0;
    lo = dst[7:0];
    if (byteMode) begin
      // Byte results clear the upper byte of the destination.
      o.result = {8'h00, lo + (twoStep ? 8'h02 : 8'h01)};
      o.n      = o.result[7];
      if (twoStep) begin
        o.z = (lo == incr_exec_pkg::BYTE_ONES_LESS);
        o.c = (lo == incr_exec_pkg::BYTE_ONES_LESS) ||
              (lo == incr_exec_pkg::BYTE_ALL_ONES);
        o.v = (lo == incr_exec_pkg::BYTE_POS_LESS) ||
              (lo == incr_exec_pkg::BYTE_POS_MAX);
      end else begin
        o.z = (lo == incr_exec_pkg::BYTE_ALL_ONES);
        o.c = (lo == incr_exec_pkg::BYTE_ALL_ONES);
        o.v = (lo == incr_exec_pkg::BYTE_POS_MAX);
      end
    end else begin
      o.result = dst + (twoStep ? 16'h0002 : 16'h0001);
      o.n      = o.result[15];
      if (twoStep) begin
        o.z = (dst == incr_exec_pkg::WORD_ONES_LESS);
        o.c = (dst == incr_exec_pkg::WORD_ONES_LESS) ||
              (dst == incr_exec_pkg::WORD_ALL_ONES);
        o.v = (dst == incr_exec_pkg::WORD_POS_LESS) ||
              (dst == incr_exec_pkg::WORD_POS_MAX);
      end else begin
        o.z = (dst == incr_exec_pkg::WORD_ALL_ONES);
        o.c = (dst == incr_exec_pkg::WORD_ALL_ONES);
        o.v = (dst == incr_exec_pkg::WORD_POS_MAX);
      end
    end
    increment = o;
  endfunction

  // Bus phase qualifiers; every access waits one cycle so read data is settled.
  // Timing of one transfer while the unit is idle:
  //   setup cycle     psel high, penable low; nothing is decided yet.
  //   first access    read data is captured and the wait flag rises at its end.
  //   second access   pready is high; a write takes effect at its closing edge.
  // A command keeps the bus waiting through fetch, execute and one more cycle,
  // so a transfer never meets the register file in the middle of a writeback.
  // The cost is up to two extra wait cycles after a command write, which
  // software sees only as a slower bus.
  assign busy      = (state != incr_exec_pkg::ST_IDLE);
  assign accessSel = decode(paddr);
  assign pready    = psel && penable && ackPending;
  assign apbDone   = pready;
  assign apbWrite  = apbDone && pwrite;
  assign apbRead   = psel && penable && !ackPending && !busy && !wbLag && !pwrite;
  assign pslverr   = pready && (accessSel == SEL_NONE);

  // The wait flag rises in the first access cycle, but only while no operation runs.
  // A writeback in the previous cycle counts as running, as its word is not readable yet.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ackPending <= 1'b0;
    end else if (apbDone) begin
      ackPending <= 1'b0;
    end else if (psel && penable && !busy && !wbLag) begin
      ackPending <= 1'b1;
    end
  end

  // Read data is captured in the access cycle in which the wait flag rises, and held until the next read.
  // Holding it lets a slow master take the word at any later point of the transfer.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata <= incr_exec_pkg::ZERO_WORD;
    end else if (apbRead) begin
      case (accessSel)
        SEL_CMD:     prdata <= {24'h000000, lastCmd};
        SEL_FLAGS:   prdata <= {16'h0000, flagRegister};
        SEL_REGIDX:  prdata <= {28'h0000000, regIdx};
        SEL_REGDATA: prdata <= {16'h0000, memRdData};
        SEL_STATUS:  prdata <= {28'h0000000, irqGrant, irqRequest, shadow, busy};
        SEL_RESULT:  prdata <= {16'h0000, lastResult};
        SEL_RETIRED: prdata <= {16'h0000, retired};
        default:     prdata <= incr_exec_pkg::ZERO_WORD;
      endcase
    end
  end

  // Register index for software access to the register file.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      regIdx <= 4'h0;
    end else if (apbWrite && accessSel == SEL_REGIDX) begin
      regIdx <= pwdata[3:0];
    end
  end

  // Command capture; a write to the command register launches one operation.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lastCmd <= 8'h00;
      curOp   <= incr_exec_pkg::OP_NONE;
      curByte <= 1'b0;
      curDest <= 4'h0;
    end else if (apbWrite && accessSel == SEL_CMD) begin
      lastCmd <= pwdata[7:0];
      curOp   <= incr_exec_pkg::op_t'(pwdata[incr_exec_pkg::CMD_OP_LSB +: 2]);
      curByte <= pwdata[incr_exec_pkg::CMD_BYTE_BIT];
      curDest <= pwdata[incr_exec_pkg::CMD_DEST_LSB +: incr_exec_pkg::REG_IDX_WIDTH];
    end
  end

  // Sequence: fetch the destination, then compute and write back in one cycle.
  // Fetch exists only because the register file answers one cycle after the address.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= incr_exec_pkg::ST_IDLE;
    end else begin
      case (state)
        incr_exec_pkg::ST_IDLE: begin
          if (apbWrite && accessSel == SEL_CMD) begin
            state <= incr_exec_pkg::ST_FETCH;
          end
        end
        incr_exec_pkg::ST_FETCH: begin
          state <= incr_exec_pkg::ST_EXEC;
        end
        incr_exec_pkg::ST_EXEC: begin
          state <= incr_exec_pkg::ST_IDLE;
        end
        default: begin
          state <= incr_exec_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Arithmetic outcome for the operand fetched from the register file.
  assign outcome  = increment(memRdData, curByte, curOp == incr_exec_pkg::OP_INCR_TWO);
  assign execDone = (state == incr_exec_pkg::ST_EXEC);

  // The register file read port is registered, so a read right after a writeback
  // would still see the old word; this flag stalls the bus for that one cycle.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wbLag <= 1'b0;
    end else begin
      wbLag <= execDone;
    end
  end

  // Register file ports; software and execution never collide because the bus stalls.
  // In idle the read port follows the software index so a data read is ready at once.
  assign memRdAddr = (state == incr_exec_pkg::ST_IDLE) ? regIdx : curDest;
  assign memWrEn   = (execDone && (curOp == incr_exec_pkg::OP_INCR_ONE ||
                                   curOp == incr_exec_pkg::OP_INCR_TWO)) ||
                     (apbWrite && accessSel == SEL_REGDATA);
  assign memWrAddr = execDone ? curDest : regIdx;
  assign memWrData = execDone ? outcome.result : pwdata[15:0];

  reg_file_mem regFile (
    .clk    (clk),
    .wrEn   (memWrEn),
    .wrAddr (memWrAddr),
    .wrData (memWrData),
    .rdAddr (memRdAddr),
    .rdData (memRdData)
  );

  // Flag register: software writes, enable-interrupt and increment updates.
  // An operation outranks a software write in the same cycle; the bus stall keeps
  // the two apart, so the order matters only as a safeguard.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flagRegister <= incr_exec_pkg::FLAGS_RESET;
    end else if (execDone && curOp == incr_exec_pkg::OP_IRQ_ENABLE) begin
      // OR with the constant touches only the enable bit.
      flagRegister <= flagRegister | incr_exec_pkg::IRQ_ENABLE_MASK;
    end else if (execDone && curOp != incr_exec_pkg::OP_NONE) begin
      // Only the four arithmetic flags move; mode bits keep their value.
      flagRegister[incr_exec_pkg::FLAG_C_BIT] <= outcome.c;
      flagRegister[incr_exec_pkg::FLAG_Z_BIT] <= outcome.z;
      flagRegister[incr_exec_pkg::FLAG_N_BIT] <= outcome.n;
      flagRegister[incr_exec_pkg::FLAG_V_BIT] <= outcome.v;
    end else if (apbWrite && accessSel == SEL_FLAGS) begin
      flagRegister <= pwdata[15:0];
    end
  end

  // Last computed result for software inspection.
  // The enable operation leaves it alone, so it always shows an increment.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lastResult <= 16'h0000;
    end else if (execDone && curOp != incr_exec_pkg::OP_IRQ_ENABLE &&
                 curOp != incr_exec_pkg::OP_NONE) begin
      lastResult <= outcome.result;
    end
  end

  // An instruction completes here or elsewhere in the core.
  assign instrDone = execDone || instrRetire;

  // Count of completed instructions.
  // It wraps at 16 bits; software only uses it to see that work went on.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      retired <= 16'h0000;
    end else if (instrDone) begin
      retired <= retired + 16'h0001;
    end
  end

  // Shadow after enable-interrupt: held until the following instruction completes,
  // so a request already waiting cannot cut in ahead of it.
  // Setting wins over clearing, so the enable operation cannot end its own shadow.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shadow <= 1'b0;
    end else if (execDone && curOp == incr_exec_pkg::OP_IRQ_ENABLE) begin
      shadow <= 1'b1;
    end else if (instrDone) begin
      shadow <= 1'b0;
    end
  end

  // Grant is withheld during the shadow and while an operation is in flight.
  // The request is not latched here; the core holds it until it is taken.
  assign irqGrant = irqRequest && flagRegister[incr_exec_pkg::FLAG_GIE_BIT] &&
                    !shadow && !busy;

  // Global enable level straight from the flag register.
  assign globalIrqEnable = flagRegister[incr_exec_pkg::FLAG_GIE_BIT];

endmodule

// ==== bench/incr_exec_assertions.sv ====
// Checker of bus and core-side timing for the increment execution unit.
`timescale 1ns/10ps

module incr_exec_assertions (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_b,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core side.
  input wire logic        irqRequest,
  input wire logic        instrRetire,
  input wire logic        irqGrant,
  input wire logic        globalIrqEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic cmdDone;
  logic flagsDone;
  // Completed writes of the command and flag registers.
  assign cmdDone   = pready && pwrite && !pslverr && paddr == incr_exec_pkg::CMD_OFFSET;
  assign flagsDone = pready && pwrite && paddr == incr_exec_pkg::FLAGS_OFFSET;

  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_error: assert property (pready && paddr > incr_exec_pkg::RETIRED_OFFSET
    |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
  a_stall_after_cmd: assert property (cmdDone |=> !pready [*2])
    else $error("transfer completed while busy");
  a_enable_sets_gie: assert property (cmdDone && pwdata[1:0] == 2'h1 |-> ##[1:4] globalIrqEnable)
    else $error("enable op left global enable low");
  a_incr_keeps_gie: assert property (cmdDone && pwdata[1] |=> $stable(globalIrqEnable) [*4])
    else $error("increment touched global enable");
  a_shadow_no_grant: assert property ($rose(globalIrqEnable) && !$past(flagsDone) |-> !irqGrant)
    else $error("grant right after enable op");
  a_grant_has_cause: assert property (irqGrant |-> irqRequest && globalIrqEnable)
    else $error("grant without request and enable");
  a_retire_ends_shadow: assert property ((!psel) [*3] ##0 (instrRetire && globalIrqEnable
    && irqRequest) ##1 (irqRequest && !psel) |-> irqGrant)
    else $error("no grant after retire");
  a_prdata_holds: assert property ($changed(prdata) |-> $past(psel && penable && !pwrite))
    else $error("read data changed outside a read");

  // Main scenarios.
  cover property (cmdDone && pwdata[2:0] == 3'h7);
  cover property (irqGrant);
  cover property (pready && pslverr);
endmodule

bind incr_exec incr_exec_assertions u_chk (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irqRequest(irqRequest), .instrRetire(instrRetire), .irqGrant(irqGrant),
  .globalIrqEnable(globalIrqEnable)
);

// ==== bench/core_side_model.sv ====
// Behavioural core side: one pending interrupt source, retire pulses, acceptance count.
`timescale 1ns/10ps

module core_side_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Bench controls.
  input  wire logic       reqArm,
  input  wire logic       retireGo,
  output logic      [7:0] acceptCount,
  // Unit side.
  input  wire logic       irqGrant,
  output logic            irqRequest,
  output logic            instrRetire
);
  logic taken;

  // A grant is taken at once, so the request drops; it re-arms only after reqArm falls.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      taken       <= 1'b0;
      irqRequest  <= 1'b0;
      instrRetire <= 1'b0;
      acceptCount <= 8'h00;
    end else begin
      taken       <= reqArm && (taken || irqGrant);
      irqRequest  <= reqArm && !(taken || irqGrant);
      instrRetire <= retireGo;
      if (irqGrant && irqRequest) begin
        acceptCount <= acceptCount + 8'h01;
      end
    end
  end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the increment execution unit.
`timescale 1ns/10ps

module testbench;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irqRequest;
  logic        instrRetire;
  logic        irqGrant;
  logic        globalIrqEnable;
  logic        reqArm;
  logic        retireGo;
  logic [7:0]  acceptCount;
  logic [31:0] rd;
  logic        err;
  int          n_fail;
  int          n_compared;
  // Five word operands, then five byte operands, three of them with stray high bytes.
  logic [15:0] vals [10] = '{16'hffff, 16'hfffe, 16'h7fff, 16'h7ffe, 16'h1234,
                             16'ha5ff, 16'h00fe, 16'h347f, 16'h007e, 16'h8010};

  incr_exec dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irqRequest(irqRequest), .instrRetire(instrRetire), .irqGrant(irqGrant),
    .globalIrqEnable(globalIrqEnable)
  );

  core_side_model u_core (
    .clk(clk), .rst_b(rst_b), .reqArm(reqArm), .retireGo(retireGo),
    .acceptCount(acceptCount), .irqGrant(irqGrant), .irqRequest(irqRequest),
    .instrRetire(instrRetire)
  );

  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; pready is sampled at each rising edge, and the edge that sees it
  // high completes the transfer, takes the read data and only then releases the bus.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) n_fail++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [15:0] exp_res(input logic two, input logic bsel,
                                          input logic [15:0] v);
    logic [15:0] k;
    k = two ? 16'h0002 : 16'h0001;
    return bsel ? {8'h00, v[7:0] + k[7:0]} : v + k;
  endfunction

  function automatic logic [15:0] exp_flags(input logic two, input logic bsel,
                                            input logic [15:0] v, input logic [15:0] f);
    logic [15:0] r;
    logic [15:0] o;
    logic [15:0] ones;
    logic [15:0] pmax;
    r    = exp_res(two, bsel, v);
    o    = bsel ? {8'h00, v[7:0]} : v;
    ones = bsel ? {8'h00, incr_exec_pkg::BYTE_ALL_ONES} : incr_exec_pkg::WORD_ALL_ONES;
    pmax = bsel ? {8'h00, incr_exec_pkg::BYTE_POS_MAX} : incr_exec_pkg::WORD_POS_MAX;
    f[incr_exec_pkg::FLAG_N_BIT] = bsel ? r[7] : r[15];
    f[incr_exec_pkg::FLAG_Z_BIT] = (o == ones - {15'h0000, two});
    f[incr_exec_pkg::FLAG_C_BIT] = (o == ones) || (two && o == ones - 16'h0001);
    f[incr_exec_pkg::FLAG_V_BIT] = (o == pmax) || (two && o == pmax - 16'h0001);
    return f;
  endfunction

  task automatic run_incr(input logic two, input logic bsel, input logic [3:0] dst,
                          input logic [15:0] v, input logic [15:0] f);
    logic [15:0] e;
    apb(1'b1, incr_exec_pkg::REGIDX_OFFSET, {28'h0, dst});
    apb(1'b1, incr_exec_pkg::REGDATA_OFFSET, {16'h0, v});
    apb(1'b1, incr_exec_pkg::FLAGS_OFFSET, {16'h0, f});
    apb(1'b1, incr_exec_pkg::CMD_OFFSET, {24'h0, dst, 1'b0, bsel, 1'b1, two});
    apb(1'b0, incr_exec_pkg::REGDATA_OFFSET, 32'h0);
    check(rd, {16'h0, exp_res(two, bsel, v)});
    apb(1'b0, incr_exec_pkg::RESULT_OFFSET, 32'h0);
    check(rd, {16'h0, exp_res(two, bsel, v)});
    e = exp_flags(two, bsel, v, f);
    apb(1'b0, incr_exec_pkg::FLAGS_OFFSET, 32'h0);
    check(rd, {16'h0, e});
  endtask

  task automatic run_enable(input logic [15:0] f);
    apb(1'b1, incr_exec_pkg::FLAGS_OFFSET, {16'h0, f});
    apb(1'b1, incr_exec_pkg::CMD_OFFSET, 32'h0000_0001);
    apb(1'b0, incr_exec_pkg::FLAGS_OFFSET, 32'h0);
    check(rd, {16'h0, f | incr_exec_pkg::IRQ_ENABLE_MASK});
  endtask

  task automatic end_of_test;
    $display("Checks: %0d compared, %0d failed", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A hang is cut short well past the expected run of under a thousand cycles.
  initial begin
    #(50 * 20000);
    n_fail++;
    end_of_test();
  end

  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; reqArm = 1'b0; retireGo = 1'b0;
    n_fail = 0; n_compared = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, incr_exec_pkg::FLAGS_OFFSET, 32'h0);
    check(rd, incr_exec_pkg::ZERO_WORD);
    apb(1'b0, incr_exec_pkg::STATUS_OFFSET, 32'h0);
    check(rd, incr_exec_pkg::ZERO_WORD);
    // Destinations 4 to 13 keep byte double increments off the stack pointer.
    for (int o = 0; o < 2; o++) begin
      for (int i = 0; i < 10; i++) begin
        run_incr(o[0], i >= 5, 4'h4 + i[3:0], vals[i], i[0] ? 16'h0107 : 16'h0038);
      end
    end
    run_enable(16'h0137);
    run_enable(16'h0100);
    // A request already pending when enabled waits for the next instruction to retire.
    apb(1'b1, incr_exec_pkg::FLAGS_OFFSET, 32'h0);
    reqArm <= 1'b1;
    apb(1'b1, incr_exec_pkg::CMD_OFFSET, 32'h0000_0001);
    apb(1'b0, incr_exec_pkg::STATUS_OFFSET, 32'h0);
    check(rd, 32'h0000_0006);
    check({31'h0, globalIrqEnable}, 32'h1);
    check({24'h0, acceptCount}, 32'h0);
    repeat (3) @(posedge clk);
    retireGo <= 1'b1;
    @(posedge clk);
    retireGo <= 1'b0;
    repeat (3) @(posedge clk);
    check({24'h0, acceptCount}, 32'h1);
    // The same, with the next command ending the shadow.
    reqArm <= 1'b0;
    apb(1'b1, incr_exec_pkg::FLAGS_OFFSET, 32'h0);
    reqArm <= 1'b1;
    apb(1'b1, incr_exec_pkg::CMD_OFFSET, 32'h0000_0001);
    apb(1'b0, incr_exec_pkg::STATUS_OFFSET, 32'h0);
    check({24'h0, acceptCount}, 32'h1);
    apb(1'b1, incr_exec_pkg::CMD_OFFSET, 32'h0000_0000);
    apb(1'b0, incr_exec_pkg::STATUS_OFFSET, 32'h0);
    check({24'h0, acceptCount}, 32'h2);
    // Unmapped place: refused, write dropped, read gives zero.
    apb(1'b1, 8'h40, 32'hffff_ffff);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check(rd, incr_exec_pkg::ZERO_WORD);
    check({31'h0, err}, 32'h1);
    end_of_test();
  end
endmodule
